// *** hw/sdadc_pkg.sv ***
// Shared constants for the dual sigma-delta converter control block.
// Assumes a 32-bit Avalon-MM register bus with byte addressing.
package sdadc_pkg;

  localparam int unsigned N_CONV = 2;
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned DATA_W = 24;

  // Register byte offsets inside one converter's window
  localparam logic [4:0] OFS_CON = 5'h00;
  localparam logic [4:0] OFS_MDE = 5'h04;
  localparam logic [4:0] OFS_STA = 5'h08;
  localparam logic [4:0] OFS_DAT = 5'h0C;
  localparam logic [4:0] OFS_S2DAT = 5'h10;
  localparam logic [4:0] OFS_IST = 5'h14;
  localparam logic [4:0] OFS_IMSK = 5'h18;
  // Window selects (address bits 6:5) and the shared ground switch register
  localparam logic [1:0] WIN_CONV0 = 2'h0;
  localparam logic [1:0] WIN_CONV1 = 2'h1;
  localparam logic [ADDR_W-1:0] ADR_GND = 7'h40;

  // converter_control_word fields
  localparam int unsigned CON_NEG_LSB = 0;
  localparam int unsigned CON_POS_LSB = 5;
  localparam int unsigned CON_REF_LSB = 10;
  localparam int unsigned CON_REFBUF_BIT = 12;
  localparam int unsigned CON_EN_BIT = 13;
  localparam int unsigned CON_SINC2_BIT = 14;
  localparam int unsigned CON_W = 15;
  localparam logic [CON_W-1:0] CON_RST = 15'h0000;

  // converter_mode_word fields
  localparam int unsigned MDE_SINC4_BIT = 0;
  localparam int unsigned MDE_GAIN_LSB = 4;
  localparam int unsigned MDE_W = 8;
  localparam logic [MDE_W-1:0] MDE_RST = 8'h00;

  // converter_status_word and interrupt bits
  localparam int unsigned STA_RDY_BIT = 0;
  localparam int unsigned STA_S2RDY_BIT = 1;
  localparam int unsigned STA_ERR_BIT = 4;
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned IRQ_RDY = 0;
  localparam int unsigned IRQ_S2 = 1;
  localparam int unsigned IRQ_ERR = 2;

  // Channel codes of the shared input multiplexer
  localparam logic [4:0] CH_AIN_LAST = 5'h0B;
  localparam logic [4:0] CH_AGND = 5'h0C;
  localparam logic [4:0] CH_AVDD_DIV4 = 5'h0D;
  localparam logic [4:0] CH_IOVDD_DIV4 = 5'h0E;
  localparam logic [4:0] CH_TEMP = 5'h0F;
  localparam logic [4:0] CH_DAC = 5'h10;

  // Reference select encodings
  localparam logic [1:0] REF_BANDGAP = 2'h0;
  localparam logic [1:0] REF_EXT1 = 2'h1;
  localparam logic [1:0] REF_EXT2 = 2'h2;

  // Error saturation codes per gain setting (1,2,4..128)
  localparam logic [7:0][DATA_W-1:0] FS_POS = {8{24'h7FFFFF}};
  localparam logic [7:0][DATA_W-1:0] FS_NEG = {8{24'h800000}};

  // Fast filter output period
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned SINC2_PERIOD_US = 2000;
  localparam int unsigned SINC2_CYCLES = (CLK_HZ / 1_000_000) * SINC2_PERIOD_US;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ACK = 1'b1
  } bus_state_e;

endpackage : sdadc_pkg

// *** hw/sdadc_result_path.sv ***
// Result handling of one converter: latching, error saturation, fast-filter pacing.
// Assumes main and fast filter words arrive synchronous to clk_sys_i.
`timescale 1ns/1ps
module sdadc_result_path #(
  parameter int unsigned SINC2_CYCLES = sdadc_pkg::SINC2_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic conv_en_i,
  input wire logic sinc2_en_i,
  input wire logic [2:0] gain_i,
  input wire logic main_valid_i,
  input wire logic [sdadc_pkg::DATA_W-1:0] main_data_i,
  input wire logic ovf_i,
  input wire logic unf_i,
  input wire logic [sdadc_pkg::DATA_W-1:0] sinc2_data_i,
  output logic [sdadc_pkg::DATA_W-1:0] result_o,
  output logic [sdadc_pkg::DATA_W-1:0] sinc2_result_o,
  output logic err_o,
  output logic rdy_pulse_o,
  output logic sinc2_pulse_o,
  output logic err_pulse_o
);

  typedef struct packed {
    logic [sdadc_pkg::DATA_W-1:0] result;
    logic [sdadc_pkg::DATA_W-1:0] sinc2;
    logic [31:0] tick;
    logic err;
    logic rdy;
    logic s2rdy;
    logic errp;
  } path_s;

  path_s st_q, st_d;

  always_comb begin
    st_d = st_q;
    st_d.rdy = 1'b0;
    st_d.s2rdy = 1'b0;
    st_d.errp = 1'b0;
    if (conv_en_i && main_valid_i) begin
      st_d.rdy = 1'b1;
      st_d.err = ovf_i | unf_i;
      st_d.errp = ovf_i | unf_i;
      if (ovf_i) begin
        st_d.result = sdadc_pkg::FS_POS[gain_i];
      end else if (unf_i) begin
        st_d.result = sdadc_pkg::FS_NEG[gain_i];
      end else begin
        st_d.result = main_data_i;
      end
    end
    // Fast filter runs beside the main path, paced by its own timer
    if (conv_en_i && sinc2_en_i) begin
      if (st_q.tick >= SINC2_CYCLES - 1) begin
        st_d.tick = '0;
        st_d.sinc2 = sinc2_data_i;
        st_d.s2rdy = 1'b1;
      end else begin
        st_d.tick = st_q.tick + 32'h00000001;
      end
    end else begin
      st_d.tick = '0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign result_o = st_q.result;
  assign sinc2_result_o = st_q.sinc2;
  assign err_o = st_q.err;
  assign rdy_pulse_o = st_q.rdy;
  assign sinc2_pulse_o = st_q.s2rdy;
  assign err_pulse_o = st_q.errp;

endmodule : sdadc_result_path

// *** hw/sdadc_ctrl.sv ***
// Control and result handling for two sigma-delta converters on one input mux.
// Assumes an Avalon-MM master on the same clock and analog filters that deliver
// finished main-filter words with overflow/underflow flags.
//
// Implementation choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module sdadc_ctrl #(
  parameter int unsigned SINC2_CYCLES = sdadc_pkg::SINC2_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic [sdadc_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [1:0] main_valid_i,
  input wire logic [1:0][sdadc_pkg::DATA_W-1:0] main_data_i,
  input wire logic [1:0] ovf_i,
  input wire logic [1:0] unf_i,
  input wire logic [1:0][sdadc_pkg::DATA_W-1:0] sinc2_data_i,
  output logic [1:0][4:0] pos_sel_o,
  output logic [1:0][4:0] neg_sel_o,
  output logic [1:0][1:0] ref_sel_o,
  output logic [1:0] ref_buf_o,
  output logic [1:0] conv_en_o,
  output logic [1:0] sinc4_sel_o,
  output logic [1:0] sinc2_en_o,
  output logic [1:0][2:0] gain_o,
  output logic gnd_sw_o,
  output logic [1:0] irq_o
);

  typedef struct packed {
    sdadc_pkg::bus_state_e bus;
    logic [31:0] rdata;
    logic [1:0][sdadc_pkg::CON_W-1:0] con;
    logic [1:0][sdadc_pkg::MDE_W-1:0] mde;
    logic [1:0][sdadc_pkg::IRQ_W-1:0] ist;
    logic [1:0][sdadc_pkg::IRQ_W-1:0] imsk;
    logic [1:0] rdy;
    logic [1:0] s2rdy;
    logic [1:0][4:0] pos;
    logic [1:0][4:0] neg;
    logic gnd;
    logic [1:0] irq;
  } ctrl_s;

  ctrl_s st_q, st_d;

  logic [1:0][sdadc_pkg::DATA_W-1:0] result;
  logic [1:0][sdadc_pkg::DATA_W-1:0] sinc2_result;
  logic [1:0] err_lvl;
  logic [1:0] rdy_p;
  logic [1:0] s2_p;
  logic [1:0] err_p;

  // One result path per converter; they never share state
  for (genvar c = 0; c < sdadc_pkg::N_CONV; c++) begin : g_conv
    sdadc_result_path #(
      .SINC2_CYCLES(SINC2_CYCLES)
    ) u_path (
      .clk_sys_i(clk_sys_i),
      .arst_n_i(arst_n_i),
      .conv_en_i(st_q.con[c][sdadc_pkg::CON_EN_BIT]),
      .sinc2_en_i(st_q.con[c][sdadc_pkg::CON_SINC2_BIT]),
      .gain_i(st_q.mde[c][sdadc_pkg::MDE_GAIN_LSB +: 3]),
      .main_valid_i(main_valid_i[c]),
      .main_data_i(main_data_i[c]),
      .ovf_i(ovf_i[c]),
      .unf_i(unf_i[c]),
      .sinc2_data_i(sinc2_data_i[c]),
      .result_o(result[c]),
      .sinc2_result_o(sinc2_result[c]),
      .err_o(err_lvl[c]),
      .rdy_pulse_o(rdy_p[c]),
      .sinc2_pulse_o(s2_p[c]),
      .err_pulse_o(err_p[c])
    );
  end

  // Legal channel check; out-of-range codes park the input on AGND
  function automatic logic [4:0] mux_code(input logic [4:0] code, input logic internal_ok);
    logic [4:0] res;
    res = sdadc_pkg::CH_AGND;
    if (code <= sdadc_pkg::CH_AGND) begin
      res = code;
    end else if (internal_ok && code <= sdadc_pkg::CH_DAC) begin
      res = code;
    end
    return res;
  endfunction : mux_code

  logic req;
  logic [1:0] win;
  logic [4:0] ofs;
  logic conv_hit;
  int unsigned sel;
  assign req = avs_read_i | avs_write_i;
  assign win = avs_address_i[6:5];
  assign ofs = avs_address_i[4:0];
  assign conv_hit = (win == sdadc_pkg::WIN_CONV0) || (win == sdadc_pkg::WIN_CONV1);
  assign sel = (win == sdadc_pkg::WIN_CONV1) ? 1 : 0;

  always_comb begin
    logic [31:0] rd;
    logic [31:0] sta;
    logic do_wr;
    logic do_rd;
    rd = 32'h00000000;
    sta = 32'h00000000;
    st_d = st_q;
    do_wr = avs_write_i && (st_q.bus == sdadc_pkg::BUS_ACK);
    do_rd = avs_read_i && (st_q.bus == sdadc_pkg::BUS_IDLE);

    // Handshake: one wait cycle, then the access completes
    case (st_q.bus)
      sdadc_pkg::BUS_IDLE: begin
        if (req) begin
          st_d.bus = sdadc_pkg::BUS_ACK;
        end
      end
      sdadc_pkg::BUS_ACK: begin
        st_d.bus = sdadc_pkg::BUS_IDLE;
      end
      default: begin
        st_d.bus = sdadc_pkg::BUS_IDLE;
      end
    endcase

    // Read data is captured in the wait cycle so it stands at the completing edge
    if (do_rd) begin
      sta[sdadc_pkg::STA_RDY_BIT] = st_q.rdy[sel];
      sta[sdadc_pkg::STA_S2RDY_BIT] = st_q.s2rdy[sel];
      sta[sdadc_pkg::STA_ERR_BIT] = err_lvl[sel];
      if (avs_address_i == sdadc_pkg::ADR_GND) begin
        rd[0] = st_q.gnd;
      end else if (conv_hit && ofs == sdadc_pkg::OFS_CON) begin
        rd[sdadc_pkg::CON_W-1:0] = st_q.con[sel];
      end else if (conv_hit && ofs == sdadc_pkg::OFS_MDE) begin
        rd[sdadc_pkg::MDE_W-1:0] = st_q.mde[sel];
      end else if (conv_hit && ofs == sdadc_pkg::OFS_STA) begin
        rd = sta;
      end else if (conv_hit && ofs == sdadc_pkg::OFS_DAT) begin
        rd[sdadc_pkg::DATA_W-1:0] = result[sel];
      end else if (conv_hit && ofs == sdadc_pkg::OFS_S2DAT) begin
        rd[sdadc_pkg::DATA_W-1:0] = sinc2_result[sel];
      end else if (conv_hit && ofs == sdadc_pkg::OFS_IST) begin
        rd[sdadc_pkg::IRQ_W-1:0] = st_q.ist[sel];
      end else if (conv_hit && ofs == sdadc_pkg::OFS_IMSK) begin
        rd[sdadc_pkg::IRQ_W-1:0] = st_q.imsk[sel];
      end
      st_d.rdata = rd;
    end

    // Reading the result consumes its ready flag; a fresh result wins below
    if (do_rd && conv_hit && ofs == sdadc_pkg::OFS_DAT) begin
      st_d.rdy[sel] = 1'b0;
    end
    if (do_rd && conv_hit && ofs == sdadc_pkg::OFS_S2DAT) begin
      st_d.s2rdy[sel] = 1'b0;
    end

    if (do_wr) begin
      if (avs_address_i == sdadc_pkg::ADR_GND) begin
        st_d.gnd = avs_writedata_i[0];
      end else if (conv_hit && ofs == sdadc_pkg::OFS_CON) begin
        st_d.con[sel] = avs_writedata_i[sdadc_pkg::CON_W-1:0];
      end else if (conv_hit && ofs == sdadc_pkg::OFS_MDE) begin
        st_d.mde[sel] = avs_writedata_i[sdadc_pkg::MDE_W-1:0];
      end else if (conv_hit && ofs == sdadc_pkg::OFS_IST) begin
        st_d.ist[sel] = st_q.ist[sel] & ~avs_writedata_i[sdadc_pkg::IRQ_W-1:0];
      end else if (conv_hit && ofs == sdadc_pkg::OFS_IMSK) begin
        st_d.imsk[sel] = avs_writedata_i[sdadc_pkg::IRQ_W-1:0];
      end
    end

    // Events set after clears so a same-cycle event is never lost
    for (int c = 0; c < sdadc_pkg::N_CONV; c++) begin
      if (rdy_p[c]) begin
        st_d.rdy[c] = 1'b1;
        st_d.ist[c][sdadc_pkg::IRQ_RDY] = 1'b1;
      end
      if (s2_p[c]) begin
        st_d.s2rdy[c] = 1'b1;
        st_d.ist[c][sdadc_pkg::IRQ_S2] = 1'b1;
      end
      if (err_p[c]) begin
        st_d.ist[c][sdadc_pkg::IRQ_ERR] = 1'b1;
      end
      // Mux selects are registered from the new control word
      st_d.pos[c] = mux_code(st_d.con[c][sdadc_pkg::CON_POS_LSB +: 5], c == 1);
      st_d.neg[c] = mux_code(st_d.con[c][sdadc_pkg::CON_NEG_LSB +: 5], c == 1);
      st_d.irq[c] = |(st_d.ist[c] & st_d.imsk[c]);
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_q <= '0;
      st_q.bus <= sdadc_pkg::BUS_IDLE;
      st_q.con <= {2{sdadc_pkg::CON_RST}};
      st_q.mde <= {2{sdadc_pkg::MDE_RST}};
      st_q.pos <= {2{sdadc_pkg::CH_AGND}};
      st_q.neg <= {2{sdadc_pkg::CH_AGND}};
    end else begin
      st_q <= st_d;
    end
  end

  // Waitrequest is high while idle, so an access always sees one wait cycle
  assign avs_waitrequest_o = (st_q.bus == sdadc_pkg::BUS_IDLE);
  assign avs_readdata_o = st_q.rdata;
  assign gnd_sw_o = st_q.gnd;
  assign irq_o = st_q.irq;

  for (genvar c = 0; c < sdadc_pkg::N_CONV; c++) begin : g_out
    assign pos_sel_o[c] = st_q.pos[c];
    assign neg_sel_o[c] = st_q.neg[c];
    // Ref code 3 is unused and falls back to band gap in the analog side
    assign ref_sel_o[c] = st_q.con[c][sdadc_pkg::CON_REF_LSB +: 2];
    assign ref_buf_o[c] = st_q.con[c][sdadc_pkg::CON_REFBUF_BIT];
    assign conv_en_o[c] = st_q.con[c][sdadc_pkg::CON_EN_BIT];
    assign sinc2_en_o[c] = st_q.con[c][sdadc_pkg::CON_SINC2_BIT];
    assign sinc4_sel_o[c] = st_q.mde[c][sdadc_pkg::MDE_SINC4_BIT];
    assign gain_o[c] = st_q.mde[c][sdadc_pkg::MDE_GAIN_LSB +: 3];
  end

endmodule : sdadc_ctrl

// *** tb/sdadc_ctrl_properties.sv ***
// Checker: bus handshake and register-to-pin relations of sdadc_ctrl.
// Sees only the ports of sdadc_ctrl; bound at the foot of this file.
`timescale 1ns/1ps
module sdadc_ctrl_properties (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic [sdadc_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic avs_waitrequest_o,
  input wire logic [1:0][4:0] pos_sel_o,
  input wire logic [1:0][4:0] neg_sel_o,
  input wire logic [1:0][1:0] ref_sel_o,
  input wire logic [1:0] ref_buf_o,
  input wire logic [1:0] sinc2_en_o,
  input wire logic [1:0] sinc4_sel_o,
  input wire logic [1:0][2:0] gain_o,
  input wire logic gnd_sw_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  logic wr;
  logic [31:0] lw_q;
  assign wr = avs_write_i && !avs_waitrequest_o;
  // Holds the last completed write word, so pins are compared two edges on
  always_ff @(posedge clk_sys_i) begin
    if (wr) begin
      lw_q <= avs_writedata_i;
    end
  end
  property p_wait_one; !avs_waitrequest_o |=> avs_waitrequest_o; endproperty
  a_wait_one: assert property (p_wait_one) else $error("wait low twice");
  property p_wait_ans; (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o; endproperty
  a_wait_ans: assert property (p_wait_ans) else $error("no answer");
  property p_sel0; wr && avs_address_i == 7'h00 && avs_writedata_i[9:5] < 5'h0C && avs_writedata_i[4:0] < 5'h0C
    |-> ##2 pos_sel_o[0] == lw_q[9:5] && neg_sel_o[0] == lw_q[4:0]; endproperty
  a_sel0: assert property (p_sel0) else $error("sel0 wrong");
  property p_ref0; wr && avs_address_i == 7'h00 |-> ##2 ref_sel_o[0] == lw_q[11:10]
    && ref_buf_o[0] == lw_q[12] && sinc2_en_o[0] == lw_q[14]; endproperty
  a_ref0: assert property (p_ref0) else $error("ref0 wrong");
  property p_gain1; wr && avs_address_i == 7'h24 |-> ##2 gain_o[1] == lw_q[6:4] && sinc4_sel_o[1] == lw_q[0]; endproperty
  a_gain1: assert property (p_gain1) else $error("gain1 wrong");
  property p_gnd; wr && avs_address_i == 7'h40 |-> ##2 gnd_sw_o == lw_q[0]; endproperty
  a_gnd: assert property (p_gnd) else $error("ground switch wrong");
  property p_int0; pos_sel_o[0] <= 5'h0C && neg_sel_o[0] <= 5'h0C; endproperty
  a_int0: assert property (p_int0) else $error("internal on conv0");
  property p_sel1; wr && avs_address_i == 7'h20 && avs_writedata_i[9:5] <= 5'h10 |-> ##2 pos_sel_o[1] == lw_q[9:5];
  endproperty
  a_sel1: assert property (p_sel1) else $error("sel1 wrong");
endmodule : sdadc_ctrl_properties

bind sdadc_ctrl sdadc_ctrl_properties i_sdadc_ctrl_properties (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_waitrequest_o(avs_waitrequest_o), .pos_sel_o(pos_sel_o),
  .neg_sel_o(neg_sel_o), .ref_sel_o(ref_sel_o), .ref_buf_o(ref_buf_o), .sinc2_en_o(sinc2_en_o),
  .sinc4_sel_o(sinc4_sel_o), .gain_o(gain_o), .gnd_sw_o(gnd_sw_o));

// *** tb/sdadc_filter_model.sv ***
// Far-side model: the two filter chains that hand result words to the block.
// Driven by tasks of the bench; shares the block's clock.
`timescale 1ns/1ps
module sdadc_filter_model (
  input wire logic clk_sys_i,
  output logic [1:0] main_valid_o,
  output logic [1:0][23:0] main_data_o,
  output logic [1:0] ovf_o,
  output logic [1:0] unf_o,
  output logic [1:0][23:0] sinc2_data_o
);
  initial begin
    main_valid_o = '0;
    main_data_o = '0;
    ovf_o = '0;
    unf_o = '0;
    sinc2_data_o = '0;
  end
  // Gap models a slow or prompt filter; data line is inverted once released
  task automatic send(input int c, input logic [23:0] d, input logic ov, input logic un, input int gap);
    repeat (gap + 1) @(posedge clk_sys_i);
    main_valid_o[c] <= 1'b1;
    main_data_o[c] <= d;
    ovf_o[c] <= ov;
    unf_o[c] <= un;
    @(posedge clk_sys_i);
    main_valid_o[c] <= 1'b0;
    main_data_o[c] <= ~d;
    ovf_o[c] <= 1'b0;
    unf_o[c] <= 1'b0;
  endtask : send
  task automatic fast(input int c, input logic [23:0] d);
    sinc2_data_o[c] <= d;
  endtask : fast
endmodule : sdadc_filter_model

// *** tb/sdadc_ctrl_tb.sv ***
// Self-checking bench for sdadc_ctrl: registers, results, saturation, irq.
// Assumes the filter model drives all converter-side inputs.
`timescale 1ns/1ps
module sdadc_ctrl_tb;
  localparam int S2 = 20;
  logic clk, rst_n, rd, wr, wreq, gsw;
  logic [6:0] adr;
  logic [31:0] wd, rdo, rdat, seed;
  logic [1:0] mv, ov, un, rb, ce, s4, s2e, irq;
  logic [1:0][23:0] md, sd;
  logic [1:0][4:0] ps, ns;
  logic [1:0][1:0] rs;
  logic [1:0][2:0] gn;
  int bad_count, compares, c, p, n, e, q[$];
  logic [31:0] v, w;
  sdadc_ctrl #(.SINC2_CYCLES(S2)) i_sdadc_ctrl (.clk_sys_i(clk), .arst_n_i(rst_n), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_readdata_o(rdo), .avs_waitrequest_o(wreq),
    .main_valid_i(mv), .main_data_i(md), .ovf_i(ov), .unf_i(un), .sinc2_data_i(sd), .pos_sel_o(ps),
    .neg_sel_o(ns), .ref_sel_o(rs), .ref_buf_o(rb), .conv_en_o(ce), .sinc4_sel_o(s4), .sinc2_en_o(s2e),
    .gain_o(gn), .gnd_sw_o(gsw), .irq_o(irq));
  sdadc_filter_model i_sdadc_filter_model (.clk_sys_i(clk), .main_valid_o(mv), .main_data_o(md), .ovf_o(ov),
    .unf_o(un), .sinc2_data_o(sd));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Waits as long as the slave asks; only the watchdog ends a hung access
  task automatic bus(input logic w_i, input logic [6:0] a, input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    wd <= d;
    wr <= w_i;
    rd <= !w_i;
    do begin
      @(posedge clk);
    end while (wreq !== 1'b0);
    rdat = rdo;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  task automatic rdc(input logic [6:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask : rdc
  task automatic report_and_stop();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Whole run is a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    report_and_stop();
  end
  initial begin
    rst_n = 1'b0;
    {rd, wr, adr, wd} = '0;
    seed = 32'h000000E8;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rdc(7'h08, 32'h0);
    rdc(7'h7C, 32'h0);
    for (int i = 0; i < 10; i++) begin
      c = i % 2;
      v = rnd();
      p = v[4:0] % 17;
      n = v[9:5] % 17;
      w = (v[14:12] << 12) | ((v[11:10] % 3) << 10) | (p << 5) | n;
      bus(1'b1, 7'(c * 32), w);
      repeat (2) @(posedge clk);
      chk(ps[c], (c == 0 && p > 12) ? 12 : p);
      chk(ns[c], (c == 0 && n > 12) ? 12 : n);
      chk({rb[c], rs[c]}, w[12:10]);
      chk({s2e[c], ce[c]}, w[14:13]);
      if (c == 1 || (p < 13 && n < 13)) rdc(7'(c * 32), w);
    end
    for (int g = 0; g < 16; g++) begin
      c = g % 2;
      bus(1'b1, 7'(c * 32 + 4), ((g / 2) << 4) | g[1]);
      repeat (2) @(posedge clk);
      chk(gn[c], g / 2);
      chk(s4[c], g[1]);
    end
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, 7'(i * 32), 32'h2000);
      bus(1'b1, 7'(i * 32 + 24), 32'h7);
      bus(1'b1, 7'(i * 32 + 20), 32'h7);
      bus(1'b0, 7'(i * 32 + 16), 32'h0);
    end
    for (int k = 0; k < 8; k++) begin
      c = k % 2;
      v = rnd();
      e = k[1] ? 32'h7FFFFF : (k[2] ? 32'h800000 : v[23:0]);
      q.push_back(e);
      i_sdadc_filter_model.send(c, v[23:0], k[1], k[2], k);
      repeat (3) @(posedge clk);
      chk(irq[c], 1);
      rdc(7'(c * 32 + 8), (k[1] | k[2]) ? 32'h00000011 : 32'h00000001);
      rdc(7'(c * 32 + 12), q.pop_front());
      rdc(7'(c * 32 + 8), (k[1] | k[2]) ? 32'h00000010 : 32'h00000000);
      bus(1'b1, 7'(c * 32 + 20), 32'h7);
      repeat (2) @(posedge clk);
      chk(irq[c], 0);
    end
    bus(1'b1, 7'h18, 32'h0);
    i_sdadc_filter_model.send(0, 24'h123456, 1'b0, 1'b0, 0);
    repeat (3) @(posedge clk);
    chk(irq[0], 0);
    rdc(7'h14, 32'h1);
    bus(1'b1, 7'h18, 32'h1);
    repeat (2) @(posedge clk);
    chk(irq, 2'b01);
    bus(1'b1, 7'h20, 32'h0);
    i_sdadc_filter_model.send(1, 24'h00ABCD, 1'b0, 1'b0, 2);
    repeat (3) @(posedge clk);
    rdc(7'h2C, 32'h7FFFFF);
    for (int i = 0; i < 2; i++) begin
      v = rnd();
      i_sdadc_filter_model.fast(1, v[23:0]);
      bus(1'b1, 7'h20, 32'h6000);
      repeat (3 * S2) @(posedge clk);
      rdc(7'h28, 32'h12);
      rdc(7'h30, v[23:0]);
    end
    for (int g = 0; g < 2; g++) begin
      bus(1'b1, 7'h40, g);
      repeat (2) @(posedge clk);
      chk(gsw, g);
      rdc(7'h40, g);
    end
    // Mid-run reset: switch opens, irq drops, mux parks on AGND
    rst_n <= 1'b0;
    @(posedge clk);
    chk({ps, ns}, {4{5'h0C}});
    chk({gsw, irq, wreq}, 4'h1);
    rst_n <= 1'b1;
    rdc(7'h20, 32'h0);
    report_and_stop();
  end
endmodule : sdadc_ctrl_tb
